// [rtl/pmcb_bank.v]
`timescale 1ns/100ps
`include "pmcb_consts.vh"
// How it works
// (RULE_01) paged external temperature peak word kept
// (RULE_02) single internal temperature peak word kept
// (RULE_03) peak clear command resets all peaks
// (RULE_04) log save copies log to storage
// (RULE_05) log erase clears stored log
// (RULE_06) log returned as block read
// (RULE_07) compare command checks working against storage
// (RULE_08) bus address byte, seven bits, 0x4F
// (RULE_09) paged multiphase address byte, default 0x80
// (RULE_10) store, restore, power-up load nonvolatile settings
// (RULE_11) retry waits at least programmed delay
// (RULE_12) run held low for restart delay
// (RULE_13) paged fault pin response byte 0xC0
// (RULE_14) read-only overtemperature response byte 0xC0
// (RULE_15) read-only part identifier word
// (RULE_16) external temperature slope word, default unity
// (RULE_17) external temperature offset word, default zero
// (RULE_18) paged sense tempco word, default 0x0F3C
// (RULE_19) shared pwm setup byte, default 0x14
// (RULE_20) paged commands use selected page copy
module pmcb_bank (
  input wire clk_sys,
  input wire rst,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire cmd_write,
  input wire [15:0] cmd_wdata,
  input wire rd_next,
  input wire [15:0] iout_meas0,
  input wire [15:0] iout_meas1,
  input wire [15:0] vout_meas0,
  input wire [15:0] vout_meas1,
  input wire [15:0] vin_meas,
  input wire [15:0] temp1_meas0,
  input wire [15:0] temp1_meas1,
  input wire [15:0] temp2_meas,
  input wire meas_valid,
  input wire [15:0] pads_in,
  input wire [7:0] common_in,
  input wire [1:0] fault_event,
  input wire [7:0] log_entry,
  output reg [15:0] rd_data,
  output reg rd_valid,
  output reg [7:0] rd_len,
  output reg compare_fail,
  output reg [1:0] retry_hold,
  output reg [1:0] run_low,
  output reg [6:0] dev_address,
  output reg [7:0] pwm_setup_out,
  output reg [15:0] temp1_gain_out,
  output reg [15:0] temp1_offs_out,
  output reg [15:0] tempco_out,
  output reg [7:0] fault_resp_out
);
  // ----------------------------------------
  // working registers
  // ----------------------------------------
  reg page;
  reg [7:0] fault_pin_pwm_response [0:1];
  reg [15:0] fault_retry_wait [0:1];
  reg [15:0] run_hold_low_time [0:1];
  reg [7:0] bus_address;
  reg [7:0] shared_pwm_setup;
  reg [15:0] sense_tempco [0:1];
  reg [15:0] ext_temp_slope [0:1];
  reg [15:0] ext_temp_addend [0:1];
  reg [7:0] multiphase_group_address [0:1];
  // nonvolatile image and logs
  reg [15:0] nv_img [0:`PMCB_NV_WORDS-1];
  reg nv_loaded;
  reg [7:0] log_ram [0:`PMCB_LOG_DEPTH-1];
  reg [7:0] log_nv [0:`PMCB_LOG_DEPTH-1];
  reg [3:0] log_wp;
  reg [3:0] log_rp;
  reg cmp_diff;
  reg [15:0] tick_div;
  reg tick_ms;
  wire [1:0] retry_busy;
  wire [1:0] restart_busy;
  wire [15:0] pk_i0, pk_i1, pk_v0, pk_v1, pk_vin, pk_t0, pk_t1, pk_t2;
  integer i, j, k, n;
  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // decode a command for this code
  function is_cmd;
    input [7:0] code;
    input [7:0] want;
    begin
      is_cmd = cmd_valid && (code == want);
    end
  endfunction
  // linear11 ms value to integer ms
  function [15:0] l11_ms;
    input [15:0] v;
    reg [4:0] e;
    reg [10:0] m;
    begin
      e = v[15:11];
      m = v[10:0];
      if (e[4]) begin
        l11_ms = {5'h00, m} >> (~e + 5'h01);
      end else begin
        l11_ms = {5'h00, m} << e;
      end
    end
  endfunction
  wire do_clear = is_cmd(cmd_code, `PMCB_CMD_CLR_PEAKS); // RULE_03
  wire do_store = is_cmd(cmd_code, `PMCB_CMD_STORE_ALL);
  wire do_restore = is_cmd(cmd_code, `PMCB_CMD_RESTORE_ALL) ||
    is_cmd(cmd_code, `PMCB_CMD_SOFT_RESET);
  wire do_load = do_restore || !nv_loaded; // RULE_10
  // ----------------------------------------
  // peak trackers
  // ----------------------------------------
  pmcb_peak u_pk_i0 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(iout_meas0), .peak(pk_i0));
  pmcb_peak u_pk_i1 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(iout_meas1), .peak(pk_i1));
  pmcb_peak u_pk_v0 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(vout_meas0), .peak(pk_v0));
  pmcb_peak u_pk_v1 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(vout_meas1), .peak(pk_v1));
  pmcb_peak u_pk_vin (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(vin_meas), .peak(pk_vin));
  pmcb_peak u_pk_t0 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(temp1_meas0), .peak(pk_t0)); // RULE_01
  pmcb_peak u_pk_t1 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(temp1_meas1), .peak(pk_t1)); // RULE_01
  pmcb_peak u_pk_t2 (.clk_sys(clk_sys), .rst(rst), .clear(do_clear), .sample_valid(meas_valid),
    .sample(temp2_meas), .peak(pk_t2)); // RULE_02
  // ----------------------------------------
  // millisecond tick: 50 cycles per us
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      tick_div <= 16'h0000;
      tick_ms <= 1'b0;
    end else if (tick_div == `PMCB_MS_DIV) begin
      tick_div <= 16'h0000;
      tick_ms <= 1'b1;
    end else begin
      tick_div <= tick_div + 16'h0001;
      tick_ms <= 1'b0;
    end
  end
  // ----------------------------------------
  // retry and restart timers per channel
  // ----------------------------------------
  pmcb_delay u_retry0 (.clk_sys(clk_sys), .rst(rst), .tick_ms(tick_ms),
    .start(fault_event[0]), .ms(l11_ms(fault_retry_wait[0])), .busy(retry_busy[0])); // RULE_11
  pmcb_delay u_retry1 (.clk_sys(clk_sys), .rst(rst), .tick_ms(tick_ms),
    .start(fault_event[1]), .ms(l11_ms(fault_retry_wait[1])), .busy(retry_busy[1])); // RULE_11
  pmcb_delay u_rst0 (.clk_sys(clk_sys), .rst(rst), .tick_ms(tick_ms),
    .start(fault_event[0]), .ms(l11_ms(run_hold_low_time[0])), .busy(restart_busy[0])); // RULE_12
  pmcb_delay u_rst1 (.clk_sys(clk_sys), .rst(rst), .tick_ms(tick_ms),
    .start(fault_event[1]), .ms(l11_ms(run_hold_low_time[1])), .busy(restart_busy[1])); // RULE_12
  // ----------------------------------------
  // register writes, store and restore
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      page <= 1'b0;
      nv_loaded <= 1'b0;
      bus_address <= `PMCB_RST_ADDR; // RULE_08
      shared_pwm_setup <= `PMCB_RST_PWM_CFG; // RULE_19
      for (i = 0; i < 2; i = i + 1) begin
        fault_pin_pwm_response[i] <= `PMCB_RST_FAULT_RESP; // RULE_13
        fault_retry_wait[i] <= `PMCB_RST_RETRY;
        run_hold_low_time[i] <= `PMCB_RST_RESTART;
        sense_tempco[i] <= `PMCB_RST_TEMPCO; // RULE_18
        ext_temp_slope[i] <= `PMCB_RST_T1_GAIN; // RULE_16
        ext_temp_addend[i] <= `PMCB_RST_T1_OFFS; // RULE_17
        multiphase_group_address[i] <= `PMCB_RST_RAIL; // RULE_09
      end
    end else if (do_load) begin
      nv_loaded <= 1'b1;
      if (nv_img[23] == 16'hA5A5) begin
        bus_address <= nv_img[0][7:0]; // RULE_10
        shared_pwm_setup <= nv_img[1][7:0];
        for (i = 0; i < 2; i = i + 1) begin
          fault_pin_pwm_response[i] <= nv_img[2+i][7:0];
          fault_retry_wait[i] <= nv_img[4+i];
          run_hold_low_time[i] <= nv_img[6+i];
          sense_tempco[i] <= nv_img[8+i];
          ext_temp_slope[i] <= nv_img[10+i];
          ext_temp_addend[i] <= nv_img[12+i];
          multiphase_group_address[i] <= nv_img[14+i][7:0];
        end
      end
    end else if (cmd_valid && cmd_write) begin
      case (cmd_code)
        `PMCB_CMD_PAGE: page <= cmd_wdata[0];
        `PMCB_CMD_ADDR: bus_address <= {1'b0, cmd_wdata[6:0]}; // RULE_08
        `PMCB_CMD_PWM_CFG: shared_pwm_setup <= cmd_wdata[7:0]; // RULE_19
        `PMCB_CMD_FAULT_RESP: fault_pin_pwm_response[page] <= cmd_wdata[7:0]; // RULE_20
        `PMCB_CMD_RETRY: fault_retry_wait[page] <= cmd_wdata; // RULE_20
        `PMCB_CMD_RESTART: run_hold_low_time[page] <= cmd_wdata;
        `PMCB_CMD_TEMPCO: sense_tempco[page] <= cmd_wdata;
        `PMCB_CMD_T1_GAIN: ext_temp_slope[page] <= cmd_wdata;
        `PMCB_CMD_T1_OFFS: ext_temp_addend[page] <= cmd_wdata;
        `PMCB_CMD_RAIL: multiphase_group_address[page] <= cmd_wdata[7:0]; // RULE_09
        default: page <= page;
      endcase
    end
  end
  // nonvolatile image write on store-all
  always @(posedge clk_sys) begin
    if (rst) begin
      for (j = 0; j < `PMCB_NV_WORDS; j = j + 1) begin
        nv_img[j] <= 16'h0000;
      end
    end else if (do_store) begin
      nv_img[0] <= {8'h00, bus_address}; // RULE_10
      nv_img[1] <= {8'h00, shared_pwm_setup};
      for (j = 0; j < 2; j = j + 1) begin
        nv_img[2+j] <= {8'h00, fault_pin_pwm_response[j]};
        nv_img[4+j] <= fault_retry_wait[j];
        nv_img[6+j] <= run_hold_low_time[j];
        nv_img[8+j] <= sense_tempco[j];
        nv_img[10+j] <= ext_temp_slope[j];
        nv_img[12+j] <= ext_temp_addend[j];
        nv_img[14+j] <= {8'h00, multiphase_group_address[j]};
      end
      nv_img[23] <= 16'hA5A5;
    end
  end
  // ----------------------------------------
  // fault log: capture, save, erase, readout
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      log_wp <= 4'h0;
      for (k = 0; k < `PMCB_LOG_DEPTH; k = k + 1) begin
        log_ram[k] <= 8'h00;
        log_nv[k] <= 8'h00;
      end
    end else begin
      if (|fault_event) begin
        log_ram[log_wp] <= log_entry;
        log_wp <= log_wp + 4'h1;
      end
      if (is_cmd(cmd_code, `PMCB_CMD_LOG_SAVE)) begin
        for (k = 0; k < `PMCB_LOG_DEPTH; k = k + 1) begin
          log_nv[k] <= log_ram[k]; // RULE_04
        end
      end else if (is_cmd(cmd_code, `PMCB_CMD_LOG_ERASE)) begin
        for (k = 0; k < `PMCB_LOG_DEPTH; k = k + 1) begin
          log_nv[k] <= 8'h00; // RULE_05
        end
      end
    end
  end
  // ----------------------------------------
  // read path and compare
  // ----------------------------------------
  // any stored setting that differs from its working copy
  always @* begin
    cmp_diff = (nv_img[23] != 16'hA5A5) || (nv_img[0][7:0] != bus_address) ||
      (nv_img[1][7:0] != shared_pwm_setup);
    for (n = 0; n < 2; n = n + 1) begin
      cmp_diff = cmp_diff || (nv_img[2+n][7:0] != fault_pin_pwm_response[n]) ||
        (nv_img[4+n] != fault_retry_wait[n]) || (nv_img[6+n] != run_hold_low_time[n]) ||
        (nv_img[8+n] != sense_tempco[n]) || (nv_img[10+n] != ext_temp_slope[n]) ||
        (nv_img[12+n] != ext_temp_addend[n]) ||
        (nv_img[14+n][7:0] != multiphase_group_address[n]); // RULE_07
    end
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_len <= 8'h00;
      log_rp <= 4'h0;
      compare_fail <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (is_cmd(cmd_code, `PMCB_CMD_COMPARE)) begin
        compare_fail <= cmp_diff; // RULE_07
      end
      if (rd_next && rd_len != 8'h00) begin
        rd_data <= {8'h00, log_nv[log_rp]}; // RULE_06
        rd_valid <= 1'b1;
        log_rp <= log_rp + 4'h1;
        rd_len <= rd_len - 8'h01;
      end else if (cmd_valid && !cmd_write) begin
        rd_valid <= 1'b1;
        rd_len <= 8'h00;
        case (cmd_code)
          `PMCB_CMD_FAULT_RESP: rd_data <= {8'h00, fault_pin_pwm_response[page]}; // RULE_20
          `PMCB_CMD_OT_RESP: rd_data <= {8'h00, `PMCB_RST_OT_RESP}; // RULE_14
          `PMCB_CMD_IOUT_PEAK: rd_data <= page ? pk_i1 : pk_i0;
          `PMCB_CMD_RETRY: rd_data <= fault_retry_wait[page];
          `PMCB_CMD_RESTART: rd_data <= run_hold_low_time[page];
          `PMCB_CMD_VOUT_PEAK: rd_data <= page ? pk_v1 : pk_v0;
          `PMCB_CMD_VIN_PEAK: rd_data <= pk_vin;
          `PMCB_CMD_T1_PEAK: rd_data <= page ? pk_t1 : pk_t0; // RULE_01
          `PMCB_CMD_T2_PEAK: rd_data <= pk_t2; // RULE_02
          `PMCB_CMD_PADS: rd_data <= pads_in;
          `PMCB_CMD_ADDR: rd_data <= {8'h00, bus_address};
          `PMCB_CMD_PART_ID: rd_data <= `PMCB_PART_ID; // RULE_15
          `PMCB_CMD_COMMON: rd_data <= {8'h00, common_in};
          `PMCB_CMD_PWM_CFG: rd_data <= {8'h00, shared_pwm_setup};
          `PMCB_CMD_TEMPCO: rd_data <= sense_tempco[page];
          `PMCB_CMD_T1_GAIN: rd_data <= ext_temp_slope[page];
          `PMCB_CMD_T1_OFFS: rd_data <= ext_temp_addend[page];
          `PMCB_CMD_RAIL: rd_data <= {8'h00, multiphase_group_address[page]};
          `PMCB_CMD_PAGE: rd_data <= {15'h0000, page};
          `PMCB_CMD_LOG_READ: begin
            rd_data <= {8'h00, 4'h0, 4'hF} + 16'h0001; // block byte count
            rd_len <= 8'h10; // RULE_06
            log_rp <= 4'h0;
          end
          default: rd_data <= 16'h0000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // registered control outputs
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      retry_hold <= 2'b00;
      run_low <= 2'b00;
      dev_address <= 7'h00;
      pwm_setup_out <= 8'h00;
      temp1_gain_out <= 16'h0000;
      temp1_offs_out <= 16'h0000;
      tempco_out <= 16'h0000;
      fault_resp_out <= 8'h00;
    end else begin
      retry_hold <= retry_busy; // RULE_11
      run_low <= restart_busy; // RULE_12
      dev_address <= bus_address[6:0]; // RULE_08
      pwm_setup_out <= shared_pwm_setup; // RULE_19
      temp1_gain_out <= ext_temp_slope[page]; // RULE_16
      temp1_offs_out <= ext_temp_addend[page]; // RULE_17
      tempco_out <= sense_tempco[page]; // RULE_18
      fault_resp_out <= fault_pin_pwm_response[page]; // RULE_13
    end
  end
endmodule // pmcb_bank

// [rtl/pmcb_consts.vh]
`ifndef PMCB_CONSTS_VH
`define PMCB_CONSTS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define PMCB_CMD_PAGE 8'h00
`define PMCB_CMD_STORE_ALL 8'h15
`define PMCB_CMD_RESTORE_ALL 8'h16
`define PMCB_CMD_FAULT_RESP 8'hD5
`define PMCB_CMD_OT_RESP 8'hD6
`define PMCB_CMD_IOUT_PEAK 8'hD7
`define PMCB_CMD_RETRY 8'hDB
`define PMCB_CMD_RESTART 8'hDC
`define PMCB_CMD_VOUT_PEAK 8'hDD
`define PMCB_CMD_VIN_PEAK 8'hDE
`define PMCB_CMD_T1_PEAK 8'hDF
`define PMCB_CMD_CLR_PEAKS 8'hE3
`define PMCB_CMD_PADS 8'hE5
`define PMCB_CMD_ADDR 8'hE6
`define PMCB_CMD_PART_ID 8'hE7
`define PMCB_CMD_LOG_SAVE 8'hEA
`define PMCB_CMD_LOG_ERASE 8'hEC
`define PMCB_CMD_LOG_READ 8'hEE
`define PMCB_CMD_COMMON 8'hEF
`define PMCB_CMD_COMPARE 8'hF0
`define PMCB_CMD_T2_PEAK 8'hF4
`define PMCB_CMD_PWM_CFG 8'hF5
`define PMCB_CMD_TEMPCO 8'hF6
`define PMCB_CMD_T1_GAIN 8'hF8
`define PMCB_CMD_T1_OFFS 8'hF9
`define PMCB_CMD_RAIL 8'hFA
`define PMCB_CMD_SOFT_RESET 8'hFD
// ----------------------------------------
// reset values
// ----------------------------------------
`define PMCB_RST_FAULT_RESP 8'hC0
`define PMCB_RST_OT_RESP 8'hC0
`define PMCB_RST_RETRY 16'hFABC
`define PMCB_RST_RESTART 16'hFBE8
`define PMCB_RST_ADDR 8'h4F
`define PMCB_RST_PWM_CFG 8'h14
`define PMCB_RST_TEMPCO 16'h0F3C
`define PMCB_RST_T1_GAIN 16'h4000
`define PMCB_RST_T1_OFFS 16'h8000
`define PMCB_RST_RAIL 8'h80
`define PMCB_PART_ID 16'h5A5A
`define PMCB_PEAK_FLOOR 16'h0000
// last count of the millisecond divider
`define PMCB_MS_DIV 16'hC34F
// ----------------------------------------
// nonvolatile image size (words) and log depth (bytes)
// ----------------------------------------
`define PMCB_NV_WORDS 24
`define PMCB_LOG_DEPTH 16
`endif

// [rtl/pmcb_delay.v]
`timescale 1ns/100ps
// ----------------------------------------
// millisecond countdown, started by pulse
// ----------------------------------------
module pmcb_delay (
  input wire clk_sys,
  input wire rst,
  input wire tick_ms,
  input wire start,
  input wire [15:0] ms,
  output reg busy
);
  reg [15:0] left;
  // count ms ticks, hold busy until at least ms elapsed
  always @(posedge clk_sys) begin
    if (rst) begin
      left <= 16'h0000;
      busy <= 1'b0;
    end else if (start) begin
      left <= ms + 16'h0001;
      busy <= 1'b1;
    end else if (busy && tick_ms) begin
      if (left <= 16'h0001) begin
        busy <= 1'b0;
        left <= 16'h0000;
      end else begin
        left <= left - 16'h0001;
      end
    end
  end
endmodule // pmcb_delay

// [rtl/pmcb_peak.v]
`timescale 1ns/100ps
`include "pmcb_consts.vh"
// ----------------------------------------
// running maximum of one measurement
// ----------------------------------------
module pmcb_peak (
  input wire clk_sys,
  input wire rst,
  input wire clear,
  input wire sample_valid,
  input wire [15:0] sample,
  output reg [15:0] peak
);
  // track largest sample, restart on clear
  always @(posedge clk_sys) begin
    if (rst || clear) begin
      peak <= `PMCB_PEAK_FLOOR;
    end else if (sample_valid && sample > peak) begin
      peak <= sample;
    end
  end
endmodule // pmcb_peak

// [tb/pmcb_bank_monitor.sv]
`timescale 1ns/100ps
`include "pmcb_consts.vh"
// ----------------------------------------
// port checker for the command bank
// ----------------------------------------
module pmcb_bank_monitor (
  input wire clk_sys,
  input wire rst,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire cmd_write,
  input wire [15:0] cmd_wdata,
  input wire rd_next,
  input wire meas_valid,
  input wire [1:0] fault_event,
  input wire [15:0] rd_data,
  input wire rd_valid,
  input wire [1:0] retry_hold,
  input wire [1:0] run_low
);
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // load cycle marker, register writes there are dropped
  reg rst_d;
  always @(posedge clk_sys) begin
    rst_d <= rst;
  end
  wire rd_go = cmd_valid && !cmd_write && !rst_d;
  a_ot_fixed: assert property (
    rd_go && cmd_code == `PMCB_CMD_OT_RESP |=> rd_valid && rd_data == 16'h00C0)
    else $error("overtemp response read wrong");
  a_id_word: assert property (
    rd_go && cmd_code == `PMCB_CMD_PART_ID |=> rd_valid && rd_data == `PMCB_PART_ID)
    else $error("part identifier read wrong");
  a_log_count: assert property (
    rd_go && cmd_code == `PMCB_CMD_LOG_READ |=> rd_valid && rd_data == 16'h0010)
    else $error("block read count wrong");
  a_read_cause: assert property (
    rd_valid |-> $past(cmd_valid) || $past(rd_next))
    else $error("read answer without request");
  a_peak_cleared: assert property (
    (cmd_valid && cmd_code == `PMCB_CMD_CLR_PEAKS && !meas_valid && !rst_d) ##1 !meas_valid
    ##1 (rd_go && cmd_code == `PMCB_CMD_T1_PEAK && !meas_valid) |=> rd_data == 16'h0000)
    else $error("peak not cleared");
  a_fault_timers: assert property (
    fault_event[0] && !rst_d |-> ##[1:3] (retry_hold[0] && run_low[0]))
    else $error("fault did not start timers");
  a_run_hold: assert property (
    $rose(run_low[1]) |=> run_low[1] [*8])
    else $error("run hold dropped early");
  a_pwm_echo: assert property (
    (cmd_valid && cmd_write && cmd_code == `PMCB_CMD_PWM_CFG && !rst_d) ##1 !cmd_valid
    ##1 (rd_go && cmd_code == `PMCB_CMD_PWM_CFG)
    |=> rd_valid && rd_data == ($past(cmd_wdata, 3) & 16'h00FF))
    else $error("pwm setup readback wrong");
endmodule // pmcb_bank_monitor

bind pmcb_bank pmcb_bank_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .rd_next(rd_next),
  .meas_valid(meas_valid), .fault_event(fault_event), .rd_data(rd_data),
  .rd_valid(rd_valid), .retry_hold(retry_hold), .run_low(run_low));

// [tb/pmcb_host.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host model driving the command port
// ----------------------------------------
module pmcb_host (
  input wire clk_sys,
  input wire rd_valid,
  input wire [15:0] rd_data,
  output reg cmd_valid = 1'b0,
  output reg [7:0] cmd_code = 8'hFF,
  output reg cmd_write = 1'b0,
  output reg [15:0] cmd_wdata = 16'hFFFF,
  output reg rd_next = 1'b0
);
  // one request pulse, answer taken a cycle later, released lines scrambled
  task xfer(input [7:0] c, input w, input [15:0] v, output [15:0] d, output ok);
    begin
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_write = w;
      cmd_wdata = v;
      @(negedge clk_sys);
      d = rd_data;
      ok = rd_valid;
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_write = ~w;
      cmd_wdata = ~v;
    end
  endtask
  // block read: count word, then one byte per next pulse
  task blk(output [15:0] n, output [7:0] miss, output [127:0] b);
    reg ok;
    integer i;
    begin
      xfer(8'hEE, 1'b0, 16'h0000, n, ok);
      miss = {7'h00, ~ok};
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge clk_sys);
        rd_next = 1'b1;
        @(negedge clk_sys);
        rd_next = 1'b0;
        b[8*i +: 8] = rd_data[7:0];
        if (rd_valid !== 1'b1) begin
          miss = miss + 8'h01;
        end
      end
    end
  endtask
endmodule // pmcb_host

// [tb/test_pmcb_bank.sv]
`timescale 1ns/100ps
`include "pmcb_consts.vh"
// ----------------------------------------
// bench for the command bank
// ----------------------------------------
module test_pmcb_bank;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg meas_valid = 1'b0;
  reg [1:0] fault_event = 2'b00;
  reg [7:0] log_entry = 8'h00;
  reg [15:0] m [0:7];
  integer errors = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  wire cmd_valid, cmd_write, rd_next, rd_valid, compare_fail;
  wire [7:0] cmd_code, pwm_setup_out, fault_resp_out;
  wire [15:0] cmd_wdata, rd_data, temp1_gain_out, temp1_offs_out, tempco_out;
  wire [1:0] retry_hold, run_low;
  wire [6:0] dev_address;
  pmcb_host host_u (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_wdata(cmd_wdata), .rd_next(rd_next));
  pmcb_bank dut_u (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .rd_next(rd_next), .iout_meas0(m[0]),
    .iout_meas1(m[1]), .vout_meas0(m[2]), .vout_meas1(m[3]), .vin_meas(m[4]),
    .temp1_meas0(m[5]), .temp1_meas1(m[6]), .temp2_meas(m[7]), .meas_valid(meas_valid),
    .pads_in(16'hA5C3), .common_in(8'h6B), .fault_event(fault_event), .log_entry(log_entry),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_len(), .compare_fail(compare_fail),
    .retry_hold(retry_hold), .run_low(run_low), .dev_address(dev_address),
    .pwm_setup_out(pwm_setup_out), .temp1_gain_out(temp1_gain_out),
    .temp1_offs_out(temp1_offs_out), .tempco_out(tempco_out), .fault_resp_out(fault_resp_out));
  // clock and hang guard
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      results;
    end
  end
  task results;
    begin
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chkb(input got, input exp);
    begin
      chk({15'h0000, got}, {15'h0000, exp});
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(negedge clk_sys);
    end
  endtask
  task wr(input [7:0] c, input [15:0] v);
    reg [15:0] d;
    reg ok;
    begin
      host_u.xfer(c, 1'b1, v, d, ok);
    end
  endtask
  task rd(input [7:0] c, input [15:0] e);
    reg [15:0] d;
    reg ok;
    begin
      host_u.xfer(c, 1'b0, 16'h0000, d, ok);
      chkb(ok, 1'b1);
      chk(d, e);
    end
  endtask
  task meas(input [15:0] b);
    begin
      @(negedge clk_sys);
      for (i = 0; i < 8; i = i + 1) m[i] = b + i[15:0];
      meas_valid = 1'b1;
      @(negedge clk_sys);
      meas_valid = 1'b0;
    end
  endtask
  task t_defaults;
    begin
      rd(`PMCB_CMD_FAULT_RESP, 16'h00C0);
      rd(`PMCB_CMD_OT_RESP, 16'h00C0);
      rd(`PMCB_CMD_RETRY, 16'hFABC);
      rd(`PMCB_CMD_RESTART, 16'hFBE8);
      rd(`PMCB_CMD_ADDR, 16'h004F);
      chk({9'h000, dev_address}, 16'h004F);
      rd(`PMCB_CMD_PART_ID, `PMCB_PART_ID);
      rd(`PMCB_CMD_PWM_CFG, 16'h0014);
      rd(`PMCB_CMD_TEMPCO, 16'h0F3C);
      chk(tempco_out, 16'h0F3C);
      chk({8'h00, fault_resp_out}, 16'h00C0);
      rd(`PMCB_CMD_T1_GAIN, 16'h4000);
      rd(`PMCB_CMD_T1_OFFS, 16'h8000);
      rd(`PMCB_CMD_RAIL, 16'h0080);
      rd(`PMCB_CMD_PADS, 16'hA5C3);
      rd(`PMCB_CMD_COMMON, 16'h006B);
      rd(8'hE0, 16'h0000);
    end
  endtask
  task t_page;
    begin
      wr(`PMCB_CMD_PAGE, 16'h0001);
      wr(`PMCB_CMD_T1_GAIN, 16'h1234);
      wr(`PMCB_CMD_RAIL, 16'h0033);
      wr(`PMCB_CMD_PWM_CFG, 16'h005A);
      rd(`PMCB_CMD_PWM_CFG, 16'h005A);
      chk({8'h00, pwm_setup_out}, 16'h005A);
      rd(`PMCB_CMD_T1_GAIN, 16'h1234);
      chk(temp1_gain_out, 16'h1234);
      rd(`PMCB_CMD_RAIL, 16'h0033);
      wr(`PMCB_CMD_PAGE, 16'h0000);
      rd(`PMCB_CMD_T1_GAIN, 16'h4000);
      rd(`PMCB_CMD_RAIL, 16'h0080);
      rd(`PMCB_CMD_PWM_CFG, 16'h005A);
      wr(`PMCB_CMD_OT_RESP, 16'h0011);
      rd(`PMCB_CMD_OT_RESP, 16'h00C0);
      wr(`PMCB_CMD_ADDR, 16'h0052);
      rd(`PMCB_CMD_ADDR, 16'h0052);
    end
  endtask
  task t_peaks;
    begin
      meas(16'h0300);
      rd(`PMCB_CMD_IOUT_PEAK, 16'h0300);
      rd(`PMCB_CMD_VOUT_PEAK, 16'h0302);
      rd(`PMCB_CMD_VIN_PEAK, 16'h0304);
      rd(`PMCB_CMD_T1_PEAK, 16'h0305);
      rd(`PMCB_CMD_T2_PEAK, 16'h0307);
      wr(`PMCB_CMD_PAGE, 16'h0001);
      meas(16'h0100);
      rd(`PMCB_CMD_IOUT_PEAK, 16'h0301);
      rd(`PMCB_CMD_T1_PEAK, 16'h0306);
      rd(`PMCB_CMD_T2_PEAK, 16'h0307);
      wr(`PMCB_CMD_CLR_PEAKS, 16'h0000);
      rd(`PMCB_CMD_T1_PEAK, 16'h0000);
      rd(`PMCB_CMD_IOUT_PEAK, 16'h0000);
      rd(`PMCB_CMD_VOUT_PEAK, 16'h0000);
      rd(`PMCB_CMD_VIN_PEAK, 16'h0000);
      rd(`PMCB_CMD_T2_PEAK, 16'h0000);
      wr(`PMCB_CMD_PAGE, 16'h0000);
    end
  endtask
  task t_nv;
    begin
      wr(`PMCB_CMD_T1_OFFS, 16'h1111);
      wr(`PMCB_CMD_STORE_ALL, 16'h0000);
      idle(200);
      wr(`PMCB_CMD_COMPARE, 16'h0000);
      idle(200);
      chkb(compare_fail, 1'b0);
      wr(`PMCB_CMD_T1_OFFS, 16'h2222);
      wr(`PMCB_CMD_COMPARE, 16'h0000);
      idle(200);
      chkb(compare_fail, 1'b1);
      wr(`PMCB_CMD_RESTORE_ALL, 16'h0000);
      idle(200);
      rd(`PMCB_CMD_T1_OFFS, 16'h1111);
      chk(temp1_offs_out, 16'h1111);
      wr(`PMCB_CMD_T1_OFFS, 16'h3333);
      wr(`PMCB_CMD_SOFT_RESET, 16'h0000);
      idle(200);
      rd(`PMCB_CMD_T1_OFFS, 16'h1111);
    end
  endtask
  task t_log;
    reg [15:0] n;
    reg [7:0] miss;
    reg [127:0] b;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        @(negedge clk_sys);
        log_entry = 8'h30 + i[7:0];
        fault_event = i[1:0] + 2'b01;
        @(negedge clk_sys);
        fault_event = 2'b00;
      end
      idle(1000);
      chkb(retry_hold[0], 1'b1);
      chkb(run_low[1], 1'b1);
      wr(`PMCB_CMD_LOG_SAVE, 16'h0000);
      idle(200);
      host_u.blk(n, miss, b);
      chk(n, 16'h0010);
      chk({8'h00, miss}, 16'h0000);
      chk(b[15:0], 16'h3130);
      chk(b[31:16], 16'h0032);
      chkb(|b[127:32], 1'b0);
      wr(`PMCB_CMD_LOG_ERASE, 16'h0000);
      idle(200);
      host_u.blk(n, miss, b);
      chk({8'h00, miss}, 16'h0000);
      chkb(|b, 1'b0);
    end
  endtask
  // reset, then the scenarios in turn
  initial begin
    for (i = 0; i < 8; i = i + 1) m[i] = 16'h0000;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    idle(2);
    t_defaults;
    t_page;
    t_peaks;
    t_nv;
    t_log;
    results;
  end
endmodule // test_pmcb_bank
